// ### inc/pbm_pkg.sv
// constants for the basic management status register block
package pbm_pkg;
   // management register addresses
   localparam logic [4:0]  ADDR_CONTROL   = 5'h00;
   localparam logic [4:0]  ADDR_STATUS    = 5'h01;
   localparam logic [4:0]  ADDR_IDENT_ONE = 5'h02;
   localparam logic [4:0]  ADDR_EXT_STAT  = 5'h0F;

   // control register fixed tail bit positions
   localparam int          CTL_SPEED_HIGH  = 6;
   localparam int          CTL_ONE_WAY     = 5;
   localparam int          CTL_COLL_TEST   = 7;
   localparam int          CTL_DUPLEX      = 8;
   localparam int          CTL_SPEED_LOW   = 13;

   // control register fixed values
   localparam logic        DUPLEX_VAL      = 1'b1;
   localparam logic        COLL_TEST_VAL   = 1'b0;
   localparam logic [1:0]  SPEED_VAL       = 2'b00;
   localparam logic        ONE_WAY_VAL     = 1'b0;

   // status register bit positions
   localparam int          ST_FOUR_PAIR    = 15;
   localparam int          ST_FAST_FULL    = 14;
   localparam int          ST_FAST_HALF    = 13;
   localparam int          ST_TEN_FULL     = 12;
   localparam int          ST_TEN_HALF     = 11;
   localparam int          ST_T2_FULL      = 10;
   localparam int          ST_T2_HALF      = 9;
   localparam int          ST_EXT_STATUS   = 8;
   localparam int          ST_ONE_WAY      = 7;
   localparam int          ST_PREAMBLE     = 6;
   localparam int          ST_NEG_DONE     = 5;
   localparam int          ST_FAR_FAULT    = 4;
   localparam int          ST_NEG_CAPABLE  = 3;
   localparam int          ST_LINK_LATCHED = 2;
   localparam int          ST_JABBER       = 1;
   localparam int          ST_EXT_REGS     = 0;

   // status register values
   localparam logic [15:0] STATUS_RESET    = 16'h1009;
   localparam logic        ABILITY_YES     = 1'b1;
   localparam logic        ABILITY_NO      = 1'b0;

   // identifier word, value arbitrary
   localparam logic [15:0] IDENT_ONE_VAL   = 16'h5A3C;

   // data returned for an unmapped address
   localparam logic [15:0] UNMAPPED_VAL    = 16'h0000;

   // access sequencer states, one-hot
   typedef enum logic [2:0] {
      ACC_IDLE  = 3'b001,
      ACC_READ  = 3'b010,
      ACC_WRITE = 3'b100
   } pbm_acc_t;
endpackage

// ### design/pbm_latch_low.sv
// latch-low link status flag
`timescale 1ns/1ps
`default_nettype none
module pbm_latch_low (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // live level and read clear
   input  wire logic live,
   input  wire logic clear,
   // reported value
   output logic      value
);
   logic held_q;
   logic held_d;

   // a failure holds the bit low; a read releases it unless the link fails again
   always_comb begin
      held_d = held_q;
      if (clear) begin
         held_d = 1'b0;
      end
      if (!live) begin
         held_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         held_q <= 1'b0;
      end else begin
         held_q <= held_d;
      end
   end

   assign value = live & ~held_q;
endmodule
`default_nettype wire

// ### design/pbm_status_word.sv
// assembles the basic status word
`timescale 1ns/1ps
`default_nettype none
module pbm_status_word (
   // live inputs
   input  wire logic        negotiation_done_bit,
   input  wire logic        link_up_latched_low,
   // status word
   output logic [15:0]      status
);
   always_comb begin
      status                                    = 16'h0000;
      status[pbm_pkg::ST_FOUR_PAIR]             = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_FAST_FULL]             = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_FAST_HALF]             = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_TEN_FULL]              = pbm_pkg::ABILITY_YES;
      status[pbm_pkg::ST_TEN_HALF]              = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_T2_FULL]               = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_T2_HALF]               = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_EXT_STATUS]            = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_ONE_WAY]               = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_PREAMBLE]              = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_NEG_DONE]              = negotiation_done_bit;
      status[pbm_pkg::ST_FAR_FAULT]             = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_NEG_CAPABLE]           = pbm_pkg::ABILITY_YES;
      status[pbm_pkg::ST_LINK_LATCHED]          = link_up_latched_low;
      status[pbm_pkg::ST_JABBER]                = pbm_pkg::ABILITY_NO;
      status[pbm_pkg::ST_EXT_REGS]              = pbm_pkg::ABILITY_YES;
   end
endmodule
`default_nettype wire

// ### design/pbm_mgmt_regs.sv
// basic management control tail, status and identifier registers
//
// Function
// - duplex bit of control ignores writes and always reads one
// - collision test bit of control ignores writes and always reads zero
// - both speed select bits ignore writes and read binary 00
// - one-way enable bit ignores writes and always reads zero
// - status bits 15, 14, 13 always read zero
// - status bit 12, ten megabit full duplex ability, always reads one
// - status bits 11, 10, 9 always read zero
// - extended status present bit reads zero; no register at 0xF
// - status bit 7, one-way ability, always reads zero
// - status bit 6 reads zero; station must always send full preamble
// - status bit 5 follows the negotiation done flag
// - status bit 4, far fault, always reads zero
// - status bit 3, negotiation capable, always reads one
// - status bit 2 latches low on link failure until status is read
// - status bit 1, jabber seen, always reads zero
// - status bit 0, extended registers present, always reads one
// - identifier one register is read-only, fixed sixteen bit constant
// - status register at address 0x1, reset value 0x1009
`timescale 1ns/1ps
`default_nettype none
module pbm_mgmt_regs (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // management register port
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_rd,
   input  wire logic        mgmt_wr,
   input  wire logic [15:0] mgmt_wdata,
   output logic             mgmt_ready,
   output logic [15:0]      mgmt_rdata,
   output logic             mgmt_rvalid,
   output logic             mgmt_wack,
   // phy core status
   input  wire logic        negotiation_done_flag,
   input  wire logic        link_up_live
);
   pbm_pkg::pbm_acc_t state_q;
   pbm_pkg::pbm_acc_t state_d;
   logic [15:0]       rdata_q;
   logic [15:0]       rdata_d;
   logic [15:0]       wdata_seen_q;
   logic [15:0]       status_word;
   logic [15:0]       control_word;
   logic              link_up_latched_low;
   logic              rd_take;
   logic              wr_take;
   logic              status_clear;

   // address compare used by decode, clear and checks
   function automatic logic addr_is(input logic [4:0] a, input logic [4:0] r);
      addr_is = (a == r);
   endfunction

   // request acceptance; a read wins over a write in the same cycle
   assign mgmt_ready = (state_q == pbm_pkg::ACC_IDLE);
   assign rd_take    = mgmt_ready & mgmt_rd;
   assign wr_take    = mgmt_ready & mgmt_wr & ~mgmt_rd;
   assign mgmt_rvalid = (state_q == pbm_pkg::ACC_READ);
   assign mgmt_wack   = (state_q == pbm_pkg::ACC_WRITE);

   // access sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         pbm_pkg::ACC_IDLE: begin
            if (rd_take) begin
               state_d = pbm_pkg::ACC_READ;
            end else if (wr_take) begin
               state_d = pbm_pkg::ACC_WRITE;
            end
         end
         pbm_pkg::ACC_READ: begin
            state_d = pbm_pkg::ACC_IDLE;
         end
         pbm_pkg::ACC_WRITE: begin
            state_d = pbm_pkg::ACC_IDLE;
         end
         default: begin
            state_d = pbm_pkg::ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= pbm_pkg::ACC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // control register fixed tail; other control bits are outside this block
   always_comb begin
      control_word                          = 16'h0000;
      control_word[pbm_pkg::CTL_DUPLEX]     = pbm_pkg::DUPLEX_VAL;
      control_word[pbm_pkg::CTL_COLL_TEST]  = pbm_pkg::COLL_TEST_VAL;
      control_word[pbm_pkg::CTL_SPEED_LOW]  = pbm_pkg::SPEED_VAL[1];
      control_word[pbm_pkg::CTL_SPEED_HIGH] = pbm_pkg::SPEED_VAL[0];
      control_word[pbm_pkg::CTL_ONE_WAY]    = pbm_pkg::ONE_WAY_VAL;
   end

   // link status latch, released by a status read
   assign status_clear = rd_take & addr_is(mgmt_addr, pbm_pkg::ADDR_STATUS);

   pbm_latch_low u_link_latch (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .live    (link_up_live),
      .clear   (status_clear),
      .value   (link_up_latched_low)
   );

   // fixed abilities and live flags
   pbm_status_word u_status (
      .negotiation_done_bit (negotiation_done_flag),
      .link_up_latched_low  (link_up_latched_low),
      .status               (status_word)
   );

   // read decode; unmapped addresses, 0xF included, return zero
   always_comb begin
      rdata_d = rdata_q;
      if (rd_take) begin
         if (addr_is(mgmt_addr, pbm_pkg::ADDR_CONTROL)) begin
            rdata_d = control_word;
         end else if (addr_is(mgmt_addr, pbm_pkg::ADDR_STATUS)) begin
            rdata_d = status_word;
         end else if (addr_is(mgmt_addr, pbm_pkg::ADDR_IDENT_ONE)) begin
            rdata_d = pbm_pkg::IDENT_ONE_VAL;
         end else begin
            rdata_d = pbm_pkg::UNMAPPED_VAL;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign mgmt_rdata = rdata_q;

   // write data is taken and dropped; nothing here is writable
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wdata_seen_q <= 16'h0000;
      end else if (wr_take) begin
         wdata_seen_q <= mgmt_wdata;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   logic rd_ctl;
   logic rd_st;
   logic rd_id;
   assign rd_ctl = rd_take & addr_is(mgmt_addr, pbm_pkg::ADDR_CONTROL);
   assign rd_st  = status_clear;
   assign rd_id  = rd_take & addr_is(mgmt_addr, pbm_pkg::ADDR_IDENT_ONE);

   property p_duplex;
      rd_ctl |=> mgmt_rvalid && mgmt_rdata[pbm_pkg::CTL_DUPLEX];
   endproperty
   a_duplex: assert property (p_duplex) else $error("duplex bit not one");

   property p_coll;
      rd_ctl |=> !mgmt_rdata[pbm_pkg::CTL_COLL_TEST];
   endproperty
   a_coll: assert property (p_coll) else $error("collision test bit not zero");

   property p_speed;
      rd_ctl ##1 mgmt_rvalid |->
         !mgmt_rdata[pbm_pkg::CTL_SPEED_LOW] && !mgmt_rdata[pbm_pkg::CTL_SPEED_HIGH];
   endproperty
   a_speed: assert property (p_speed) else $error("speed bits not 00");

   property p_one_way;
      rd_ctl |=> !mgmt_rdata[pbm_pkg::CTL_ONE_WAY];
   endproperty
   a_one_way: assert property (p_one_way) else $error("one-way enable not zero");

   property p_fast;
      rd_st |=> mgmt_rdata[15:13] == 3'h0;
   endproperty
   a_fast: assert property (p_fast) else $error("fast abilities not zero");

   property p_ten_full;
      rd_st |=> mgmt_rdata[pbm_pkg::ST_TEN_FULL];
   endproperty
   a_ten_full: assert property (p_ten_full) else $error("ten full ability not one");

   property p_misc_zero;
      rd_st |=> mgmt_rdata[11:9] == 3'h0;
   endproperty
   a_misc_zero: assert property (p_misc_zero) else $error("bits 11..9 not zero");

   property p_ext_stat;
      rd_st |=> !mgmt_rdata[pbm_pkg::ST_EXT_STATUS];
   endproperty
   a_ext_stat: assert property (p_ext_stat) else $error("ext status bit set");

   property p_ext_stat_addr;
      rd_take && addr_is(mgmt_addr, pbm_pkg::ADDR_EXT_STAT) |=> mgmt_rdata == 16'h0000;
   endproperty
   a_ext_stat_addr: assert property (p_ext_stat_addr) else $error("0xF not zero");

   property p_one_way_ab;
      rd_st |=> !mgmt_rdata[pbm_pkg::ST_ONE_WAY];
   endproperty
   a_one_way_ab: assert property (p_one_way_ab) else $error("one-way ability set");

   property p_preamble;
      rd_st |=> !mgmt_rdata[pbm_pkg::ST_PREAMBLE];
   endproperty
   a_preamble: assert property (p_preamble) else $error("preamble skip set");

   property p_neg_done;
      rd_st |=> mgmt_rdata[pbm_pkg::ST_NEG_DONE] == $past(negotiation_done_flag);
   endproperty
   a_neg_done: assert property (p_neg_done) else $error("done bit mismatch");

   property p_far_fault;
      rd_st |=> !mgmt_rdata[pbm_pkg::ST_FAR_FAULT] && !mgmt_rdata[pbm_pkg::ST_JABBER];
   endproperty
   a_far_fault: assert property (p_far_fault) else $error("fault bits set");

   property p_neg_cap;
      rd_st |=> mgmt_rdata[pbm_pkg::ST_NEG_CAPABLE] && mgmt_rdata[pbm_pkg::ST_EXT_REGS];
   endproperty
   a_neg_cap: assert property (p_neg_cap) else $error("capable bits not one");

   property p_latch_low;
      !link_up_live ##1 rd_st |=> !mgmt_rdata[pbm_pkg::ST_LINK_LATCHED];
   endproperty
   a_latch_low: assert property (p_latch_low) else $error("link bit not latched");

   property p_latch_hold;
      !link_up_live |=> !link_up_latched_low;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("link bit not held");

   property p_latch_release;
      rd_st && link_up_live ##1 link_up_live |-> link_up_latched_low;
   endproperty
   a_latch_release: assert property (p_latch_release) else $error("no release");

   property p_link_follow;
      rd_st && link_up_latched_low |=> mgmt_rdata[pbm_pkg::ST_LINK_LATCHED];
   endproperty
   a_link_follow: assert property (p_link_follow) else $error("link bit not live");

   property p_jabber;
      rd_st |=> !mgmt_rdata[pbm_pkg::ST_JABBER];
   endproperty
   a_jabber: assert property (p_jabber) else $error("jabber bit set");

   property p_ext_regs;
      rd_st |=> mgmt_rdata[pbm_pkg::ST_EXT_REGS];
   endproperty
   a_ext_regs: assert property (p_ext_regs) else $error("ext regs bit not one");

   property p_ident;
      rd_id |=> mgmt_rvalid && mgmt_rdata == pbm_pkg::IDENT_ONE_VAL;
   endproperty
   a_ident: assert property (p_ident) else $error("identifier mismatch");

   property p_reset_val;
      rd_st && !negotiation_done_flag && !link_up_live
         |=> mgmt_rdata == pbm_pkg::STATUS_RESET;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("status idle value wrong");

   property p_write_null;
      wr_take |=> mgmt_wack && $stable(mgmt_rdata) ##1 mgmt_ready;
   endproperty
   a_write_null: assert property (p_write_null) else $error("write disturbed data");

   property p_wr_drop;
      rd_take && mgmt_wr |=> mgmt_rvalid && !mgmt_wack;
   endproperty
   a_wr_drop: assert property (p_wr_drop) else $error("write served with read");

   property p_rd_hold;
      !rd_take |=> $stable(mgmt_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

   property p_unmapped;
      rd_take && !rd_ctl && !rd_st && !rd_id
         |=> mgmt_rdata == pbm_pkg::UNMAPPED_VAL;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   c_read_status: cover property (rd_st ##1 mgmt_rvalid);
   c_read_ident:  cover property (rd_id ##1 mgmt_rvalid);
   c_write:       cover property (wr_take ##1 mgmt_wack);
   c_latch:       cover property (!link_up_live ##1 link_up_live [*2] ##1 rd_st);
endmodule
`default_nettype wire

// ### tb/pbm_station.sv
// management station model driving the register port
`timescale 1ns/1ps
`default_nettype none
module pbm_station (
   // clock
   input  wire logic        ref_clk,
   // management register port
   output logic [4:0]       mgmt_addr,
   output logic             mgmt_rd,
   output logic             mgmt_wr,
   output logic [15:0]      mgmt_wdata,
   input  wire logic        mgmt_ready,
   input  wire logic [15:0] mgmt_rdata,
   input  wire logic        mgmt_rvalid,
   input  wire logic        mgmt_wack
);
   initial begin
      mgmt_addr  = 5'h00;
      mgmt_rd    = 1'b0;
      mgmt_wr    = 1'b0;
      mgmt_wdata = 16'h0000;
   end

   // hold the request until an edge sees ready high
   task automatic wait_take();
      int n;
      n = 0;
      while (mgmt_ready !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   task automatic do_read(input logic [4:0] a, input logic also_wr,
                          output logic [15:0] data, output logic valid, output logic ack);
      @(negedge ref_clk);
      mgmt_addr  = a;
      mgmt_rd    = 1'b1;
      mgmt_wr    = also_wr;
      mgmt_wdata = 16'hFFFF;
      wait_take();
      @(negedge ref_clk);
      valid      = mgmt_rvalid;
      ack        = mgmt_wack;
      data       = mgmt_rdata;
      mgmt_rd    = 1'b0;
      mgmt_wr    = 1'b0;
      mgmt_addr  = ~a;
      mgmt_wdata = 16'h0000;
   endtask

   task automatic do_write(input logic [4:0] a, input logic [15:0] d, output logic ack);
      @(negedge ref_clk);
      mgmt_addr  = a;
      mgmt_wr    = 1'b1;
      mgmt_wdata = d;
      wait_take();
      @(negedge ref_clk);
      ack        = mgmt_wack;
      mgmt_wr    = 1'b0;
      mgmt_addr  = ~a;
      mgmt_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ### tb/test_pbm_mgmt_regs.sv
// testbench for the basic management register block
`timescale 1ns/1ps
`default_nettype none
`define PBM_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
   $display("Error at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module test_pbm_mgmt_regs;
   logic        ref_clk;
   logic        rstn;
   logic        negotiation_done_flag;
   logic        link_up_live;
   logic [4:0]  mgmt_addr;
   logic        mgmt_rd;
   logic        mgmt_wr;
   logic [15:0] mgmt_wdata;
   logic        mgmt_ready;
   logic [15:0] mgmt_rdata;
   logic        mgmt_rvalid;
   logic        mgmt_wack;
   int          errors;
   int          checks;
   int          cycles;
   logic [15:0] d;
   logic        v;
   logic        k;

   pbm_mgmt_regs i_pbm_mgmt_regs (
      .ref_clk(ref_clk), .rstn(rstn), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd),
      .mgmt_wr(mgmt_wr), .mgmt_wdata(mgmt_wdata), .mgmt_ready(mgmt_ready),
      .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .mgmt_wack(mgmt_wack),
      .negotiation_done_flag(negotiation_done_flag), .link_up_live(link_up_live));

   pbm_station i_pbm_station (
      .ref_clk(ref_clk), .mgmt_addr(mgmt_addr), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
      .mgmt_wdata(mgmt_wdata), .mgmt_ready(mgmt_ready), .mgmt_rdata(mgmt_rdata),
      .mgmt_rvalid(mgmt_rvalid), .mgmt_wack(mgmt_wack));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic tally_and_finish();
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // expected status word from the live flags
   function automatic logic [15:0] st(input logic nd, input logic lk);
      logic [15:0] e;
      e = pbm_pkg::STATUS_RESET;
      e[pbm_pkg::ST_NEG_DONE] = nd;
      e[pbm_pkg::ST_LINK_LATCHED] = lk;
      return e;
   endfunction

   task automatic rd(input logic [4:0] a);
      i_pbm_station.do_read(a, 1'b0, d, v, k);
      `PBM_CHK(v, 1'b1)
   endtask

   task automatic link_blip();
      @(negedge ref_clk);
      link_up_live = 1'b0;
      @(negedge ref_clk);
      link_up_live = 1'b1;
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors++;
         tally_and_finish();
      end
   end

   initial begin
      errors = 0;
      checks = 0;
      cycles = 0;
      rstn = 1'b0;
      negotiation_done_flag = 1'b0;
      link_up_live = 1'b0;
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, 16'h1009)
      for (int i = 0; i < 2; i++) begin
         rd(pbm_pkg::ADDR_CONTROL);
         `PBM_CHK(d[pbm_pkg::CTL_DUPLEX], 1'b1)
         `PBM_CHK(d[pbm_pkg::CTL_COLL_TEST], 1'b0)
         `PBM_CHK({d[pbm_pkg::CTL_SPEED_LOW], d[pbm_pkg::CTL_SPEED_HIGH]}, 2'b00)
         `PBM_CHK(d[pbm_pkg::CTL_ONE_WAY], 1'b0)
         i_pbm_station.do_write(pbm_pkg::ADDR_CONTROL, 16'hFFFF, k);
         `PBM_CHK(k, 1'b1)
      end
      i_pbm_station.do_write(pbm_pkg::ADDR_STATUS, 16'hFFFF, k);
      `PBM_CHK(k, 1'b1)
      i_pbm_station.do_write(pbm_pkg::ADDR_IDENT_ONE, 16'h0000, k);
      `PBM_CHK(k, 1'b1)
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, 16'h1009)
      rd(pbm_pkg::ADDR_IDENT_ONE);
      `PBM_CHK(d, pbm_pkg::IDENT_ONE_VAL)
      rd(pbm_pkg::ADDR_EXT_STAT);
      `PBM_CHK(d, 16'h0000)
      // read and write together: read served, write dropped
      i_pbm_station.do_read(pbm_pkg::ADDR_IDENT_ONE, 1'b1, d, v, k);
      `PBM_CHK({v, k}, 2'b10)
      `PBM_CHK(d, pbm_pkg::IDENT_ONE_VAL)
      // link held low since reset: first read shows the latched low, then live
      @(negedge ref_clk);
      link_up_live = 1'b1;
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b0, 1'b0))
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b0, 1'b1))
      negotiation_done_flag = 1'b1;
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b1, 1'b1))
      negotiation_done_flag = 1'b0;
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b0, 1'b1))
      // one-cycle drop, other reads must not release the latch
      link_blip();
      rd(pbm_pkg::ADDR_IDENT_ONE);
      rd(pbm_pkg::ADDR_CONTROL);
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b0, 1'b0))
      rd(pbm_pkg::ADDR_STATUS);
      `PBM_CHK(d, st(1'b0, 1'b1))
      tally_and_finish();
   end
endmodule
`default_nettype wire
